// >>> design/pbs_pkg.sv
// Package for the PHY basic status register block.
// Assumes a management read port where the register address arrives
// with a one-cycle read strobe on the same clock.
package pbs_pkg;
	localparam logic [4:0]  PBS_ADDR        = 5'h01;
	localparam int          PBS_WIDTH       = 16;
	localparam int          PBS_ADDR_W      = 5;
	// Field positions
	localparam int          PBS_B_T4        = 15;
	localparam int          PBS_B_TX_FD     = 14;
	localparam int          PBS_B_TX_HD     = 13;
	localparam int          PBS_B_10_FD     = 12;
	localparam int          PBS_B_10_HD     = 11;
	localparam int          PBS_B_PRE_SUP   = 6;
	localparam int          PBS_B_AN_DONE   = 5;
	localparam int          PBS_B_RFAULT    = 4;
	localparam int          PBS_B_AN_ABLE   = 3;
	localparam int          PBS_B_LINK      = 2;
	localparam int          PBS_B_JABBER    = 1;
	localparam int          PBS_B_EXT       = 0;
	// Partner ability remote fault bit position
	localparam int          PBS_B_PA_FAULT  = 13;
	// Constant part of the status word, latched bits zero
	localparam logic [15:0] PBS_FIXED       = 16'h7849;
	// Reset values of the latched flags
	localparam logic        PBS_RST_RFAULT  = 1'b0;
	localparam logic        PBS_RST_LINK    = 1'b0;
	localparam logic        PBS_RST_JABBER  = 1'b0;
	localparam logic        PBS_RST_PRE_SUP = 1'b1;
endpackage

// >>> design/pbs_sync_if.sv
// Interface carrying the synchronised event levels to the latch logic.
// Assumes both sides run on the management clock.
`timescale 1ns/10ps
`default_nettype none
interface pbs_sync_if;
	logic link_ok;
	logic fault;
	logic jabber;
	logic an_done;
	modport src (output link_ok, output fault, output jabber, output an_done);
	modport dst (input link_ok, input fault, input jabber, input an_done);
endinterface
`default_nettype wire

// >>> design/pbs_sync.sv
// Two-flop synchronisers for the PHY condition inputs.
// Assumes the conditions come from logic in other clock domains.
`timescale 1ns/10ps
`default_nettype none
module pbs_sync (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic link_ok_in,
	input  wire logic fault_in,
	input  wire logic jabber_in,
	input  wire logic an_done_in,
	pbs_sync_if.src   out
);
	logic [3:0] meta_reg;
	logic [3:0] sync_reg;

	// First stage is read only by the second stage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 4'h0;
			sync_reg <= 4'h0;
		end else begin
			meta_reg <= {an_done_in, jabber_in, fault_in, link_ok_in};
			sync_reg <= meta_reg;
		end
	end

	assign out.link_ok = sync_reg[0];
	assign out.fault   = sync_reg[1];
	assign out.jabber  = sync_reg[2];
	assign out.an_done = sync_reg[3];
endmodule
`default_nettype wire

// >>> design/pbs_status.sv
// PHY basic status register: fixed capabilities plus latched flags.
// Assumes the management frame engine issues rd_stb for one cycle with
// rd_addr, and that writes never reach this read-only register.
//
// Function
// [R1] Bit 15 always reads 0, four-pair operation unsupported; writes ignored.
// [R2] Bit 14 always reads 1, 100 Mbps full duplex supported.
// [R3] Bit 13 always reads 1, 100 Mbps half duplex supported.
// [R4] Bit 12 always reads 1, 10 Mbps full duplex supported.
// [R5] Bit 11 always reads 1, 10 Mbps half duplex supported.
// [R6] Bits 10 to 7 read zero; written values discarded.
// [R7] Bit 6 reads 1 after reset; preamble-less frames accepted.
// [R8] Bit 5 set when auto-negotiation finished, else 0.
// [R9] Bit 4 latches high on remote fault until read or reset.
// [R10] Remote fault follows partner ability remote fault bit 13.
// [R11] Bit 3 always reads 1, auto-negotiation able.
// [R12] Bit 2 reports valid link at 10 or 100; reset value 0.
// [R13] Link bit latches low on failure until read, despite recovery.
// [R14] Bit 1 latches high on jabber until read or reset.
// [R15] Jabber flagged only at 10 Mbps, never at 100 Mbps.
// [R16] Bit 0 always reads 1, extended registers implemented.
// [R17] Read returns latched value, then releases; persisting condition relatches.
`timescale 1ns/10ps
`default_nettype none
module pbs_status #(
	parameter int ADDR_W = pbs_pkg::PBS_ADDR_W
) (
	input  wire logic               clock,
	input  wire logic               nrst,
	input  wire logic               rd_stb,
	input  wire logic [ADDR_W-1:0]  rd_addr,
	input  wire logic               link_ok_in,
	input  wire logic [15:0]        partner_ability_register,
	input  wire logic               jabber_in,
	input  wire logic               speed_100,
	input  wire logic               an_done_in,
	output logic [15:0]             rd_data,
	output logic                    rd_valid,
	output logic                    partner_fault_flag,
	output logic                    link_status
);
	pbs_sync_if sy ();

	logic rfault_reg;
	logic link_reg;
	logic jabber_reg;
	logic an_done_reg;
	logic hit;
	logic jab_event;
	logic speed_meta_reg;
	logic speed_sync_reg;
	logic [15:0] word;

	// Condition levels cross into the management clock here
	pbs_sync u_sync (
		.clock      (clock),
		.nrst       (nrst),
		.link_ok_in (link_ok_in),
		.fault_in   (partner_ability_register[pbs_pkg::PBS_B_PA_FAULT]),
		.jabber_in  (jabber_in),
		.an_done_in (an_done_in),
		.out        (sy)
	);

	// Speed gets the same two-flop depth as jabber, so the gate lines up
	// and never reads an unsynchronised pin.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			speed_meta_reg <= 1'b0;
			speed_sync_reg <= 1'b0;
		end else begin
			speed_meta_reg <= speed_100;
			speed_sync_reg <= speed_meta_reg;
		end
	end

	assign hit       = rd_stb && (rd_addr == ADDR_W'(pbs_pkg::PBS_ADDR));
	// [R15] jabber speed gate
	assign jab_event = sy.jabber & ~speed_sync_reg;

	// [R10] partner fault source
	// [R9] remote fault latch
	// [R17] release after read
	// An event in the read cycle wins so a fault is never lost.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rfault_reg <= pbs_pkg::PBS_RST_RFAULT;
		end else if (sy.fault) begin
			rfault_reg <= 1'b1;
		end else if (hit) begin
			rfault_reg <= 1'b0;
		end
	end

	// [R13] link latching low
	// [R12] link status reporting
	// A failure in the read cycle wins; a read reloads the live state.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			link_reg <= pbs_pkg::PBS_RST_LINK;
		end else if (!sy.link_ok) begin
			link_reg <= 1'b0;
		end else if (hit) begin
			link_reg <= 1'b1;
		end
	end

	// [R14] jabber latch high
	// [R17] release after read
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			jabber_reg <= pbs_pkg::PBS_RST_JABBER;
		end else if (jab_event) begin
			jabber_reg <= 1'b1;
		end else if (hit) begin
			jabber_reg <= 1'b0;
		end
	end

	// [R8] negotiation complete level
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			an_done_reg <= 1'b0;
		end else begin
			an_done_reg <= sy.an_done;
		end
	end

	// Assemble the word from fixed bits and the live latches
	// [R1] T4 reads zero
	// [R2] TX full duplex
	// [R3] TX half duplex
	// [R4] ten full duplex
	// [R5] ten half duplex
	// [R6] reserved read zero
	// [R7] preamble suppression one
	// [R11] negotiation ability one
	// [R16] extended capability one
	always_comb begin
		word = pbs_pkg::PBS_FIXED;
		word[pbs_pkg::PBS_B_PRE_SUP] = pbs_pkg::PBS_RST_PRE_SUP;
		word[pbs_pkg::PBS_B_AN_DONE] = an_done_reg;
		word[pbs_pkg::PBS_B_RFAULT]  = rfault_reg;
		word[pbs_pkg::PBS_B_LINK]    = link_reg;
		word[pbs_pkg::PBS_B_JABBER]  = jabber_reg;
	end

	// [R17] latched value returned
	// Data is captured from the pre-release latches on the strobe edge.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= hit;
			if (hit) begin
				rd_data <= word;
			end
		end
	end

	// Flag copies for the rest of the PHY
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			partner_fault_flag <= 1'b0;
			link_status        <= 1'b0;
		end else begin
			partner_fault_flag <= rfault_reg;
			link_status        <= link_reg;
		end
	end
endmodule
`default_nettype wire

// >>> sim/pbs_status_sva.sv
// Checker for the status register read port and latched flags.
// Assumes one clock domain and the default address width.
`timescale 1ns/10ps
`default_nettype none
module pbs_status_sva (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        rd_stb,
	input wire logic [4:0]  rd_addr,
	input wire logic        an_done_in,
	input wire logic [15:0] rd_data,
	input wire logic        rd_valid,
	input wire logic        partner_fault_flag,
	input wire logic        link_status
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// A read is taken only at the status address
	sequence s_take; rd_stb && rd_addr == 5'h01; endsequence
	// Input reaches the read word four edges later: two sync, level, capture
	sequence s_an; $past(an_done_in, 2) == $past(an_done_in, 4); endsequence
	property p_ans; s_take |=> rd_valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_ref; !(rd_stb && rd_addr == 5'h01) |=> !rd_valid; endproperty
	a_ref: assert property (p_ref) else $error("stray answer");
	property p_fix; rd_valid |-> (rd_data & 16'hFFC9) == 16'h7849; endproperty
	a_fix: assert property (p_fix) else $error("fixed bits");
	property p_rf; partner_fault_flag && !rd_valid |=> partner_fault_flag;
	endproperty
	a_rf: assert property (p_rf) else $error("fault released");
	property p_ll; !link_status && !rd_valid |=> !link_status; endproperty
	a_ll: assert property (p_ll) else $error("link rose");
	property p_hold; !rd_valid |-> $stable(rd_data); endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_one; rd_valid |-> $past(rd_stb && rd_addr == 5'h01);
	endproperty
	a_one: assert property (p_one) else $error("unasked answer");
	property p_an; (rd_valid and s_an) |-> rd_data[5] == $past(an_done_in, 4);
	endproperty
	a_an: assert property (p_an) else $error("negotiation bit");
endmodule
bind pbs_status pbs_status_sva chk_u (.clock(clock), .nrst(nrst),
	.rd_stb(rd_stb), .rd_addr(rd_addr), .an_done_in(an_done_in),
	.rd_data(rd_data), .rd_valid(rd_valid),
	.partner_fault_flag(partner_fault_flag), .link_status(link_status));
`default_nettype wire

// >>> sim/pbs_mgmt_model.sv
// Management controller model: issues reads, keeps the answer.
// Assumes req is high for one cycle per read.
`timescale 1ns/10ps
`default_nettype none
module pbs_mgmt_model (
	input  wire logic        clock,
	input  wire logic        req,
	input  wire logic [4:0]  req_addr,
	input  wire logic        rd_valid,
	input  wire logic [15:0] rd_data,
	output logic             rd_stb = 1'b0,
	output logic [4:0]       rd_addr = 5'h1F,
	output logic [15:0]      word,
	output logic             done = 1'b0
);
	// Idle address toggles so a stale value can never pass
	always @(posedge clock) begin
		rd_stb <= req;
		rd_addr <= req ? req_addr : ~rd_addr;
		done <= rd_valid;
		if (rd_valid)
			word <= rd_data;
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the status register via the model.
// Assumes an answer one cycle after an accepted read.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch %0t got %h want %h", $time, a, b); end end
module tb_top;
	logic clock = 0, nrst = 0, req = 0, link = 0, jab = 0, spd = 0, an = 0;
	logic rd_stb, rd_valid, done, pff, lst, ok;
	logic [4:0] ra = 5'h01, rd_addr;
	logic [15:0] pa = 16'h0000, rd_data, word, w;
	int bad_count = 0, n_checks = 0;
	initial forever #2 clock = ~clock;
	pbs_status dut_u (.clock(clock), .nrst(nrst), .rd_stb(rd_stb),
		.rd_addr(rd_addr), .link_ok_in(link), .partner_ability_register(pa),
		.jabber_in(jab), .speed_100(spd), .an_done_in(an), .rd_data(rd_data),
		.rd_valid(rd_valid), .partner_fault_flag(pff), .link_status(lst));
	pbs_mgmt_model mgmt_u (.clock(clock), .req(req), .req_addr(ra),
		.rd_valid(rd_valid), .rd_data(rd_data), .rd_stb(rd_stb),
		.rd_addr(rd_addr), .word(word), .done(done));
	task results;
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One read, bounded wait; other addresses must stay silent
	task rd(input logic [4:0] a);
		ok = 0;
		@(posedge clock) begin req <= 1; ra <= a; end
		@(posedge clock) req <= 0;
		for (int i = 0; i < 8 && ok !== 1'b1; i++)
			@(posedge clock) ok = done;
		#1 w = word;
		`CHK(ok, a == 5'h01)
		if (ok !== 1'b1 && a == 5'h01)
			results();
	endtask
	task t_reset;
		rd(5'h01); `CHK(w[15:11], 5'h0F)
		`CHK(w[10:0], 11'h049)
		rd(5'h02);
	endtask
	// Fault held across a read relatches, then holds after it goes
	task t_fault;
		@(posedge clock) pa <= 16'h2000;
		repeat (6) @(posedge clock);
		rd(5'h01); `CHK(w[4], 1'b1)
		rd(5'h01); `CHK(w[4], 1'b1)
		@(posedge clock) pa <= 16'h0000;
		repeat (6) @(posedge clock); `CHK(pff, 1'b1)
		rd(5'h01); `CHK(w[4], 1'b1)
		rd(5'h01); `CHK(w[4], 1'b0)
		`CHK(pff, 1'b0)
	endtask
	task t_link;
		@(posedge clock) link <= 1;
		repeat (6) @(posedge clock);
		rd(5'h01); `CHK(w[2], 1'b0)
		rd(5'h01); `CHK(w[2], 1'b1)
		`CHK(lst, 1'b1)
		@(posedge clock) link <= 0;
		repeat (3) @(posedge clock);
		link <= 1;
		repeat (6) @(posedge clock); `CHK(lst, 1'b0)
		rd(5'h01); `CHK(w[2], 1'b0)
		rd(5'h01); `CHK(w[2], 1'b1)
	endtask
	// Mid-run chip reset clears a latched fault and the link bit
	task t_chip_rst;
		@(posedge clock) pa <= 16'h2000;
		repeat (6) @(posedge clock);
		pa <= 16'h0000;
		nrst <= 0;
		repeat (4) @(posedge clock); `CHK(pff, 1'b0)
		nrst <= 1;
		rd(5'h01); `CHK(w[4], 1'b0)
		`CHK(w[2], 1'b0)
	endtask
	task t_jab(input logic s, input logic e);
		@(posedge clock) begin spd <= s; jab <= 1; end
		repeat (6) @(posedge clock);
		jab <= 0;
		repeat (6) @(posedge clock);
		rd(5'h01); `CHK(w[1], e)
		rd(5'h01); `CHK(w[1], 1'b0)
	endtask
	task t_an;
		@(posedge clock) an <= 1;
		repeat (6) @(posedge clock);
		rd(5'h01); `CHK(w[5], 1'b1)
	endtask
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1;
		t_reset();
		t_fault();
		t_link();
		t_chip_rst();
		t_jab(1, 0);
		t_jab(0, 1);
		t_an();
		results();
	end
endmodule
`default_nettype wire
